// *** verilog/irs_slave.sv ***
// Two-wire register access slave: framing, address match, pointer, data
// ------------------------------------------------------------------
// What this block does
// - Bytes are eight bits, MSB first
// - Start is data falling with clock high
// - After start, shift in address and direction
// - Acknowledge own address, otherwise stay released
// - Direction 0 writes, direction 1 reads
// - Nine clocks per byte, receiver acknowledges
// - Data changes only while clock low
// - Stop abandons transfer and returns idle
// - First write byte loads address pointer
// - Then high data byte, then low byte
// - Pointer increments per register, stops at the last; loaded above it, wraps past 8'hff
// - Writes past the last register are discarded
// - Registers are 16 bits from byte pairs
// - Read sends high byte, then low byte
// - Reads advance pointer until master nacks
// - At the last register, reads repeat it
// - Upper five address bits are 01011
// - Master acks between high and low byte
// - Two low address bits follow select pins
// - Slave only: never drives the clock line
// ------------------------------------------------------------------
`timescale 1ns/1ps

module irs_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen_o,
  input wire logic addr_select_low_pin_i,
  input wire logic addr_select_high_pin_i,
  output logic reg_wr_o,
  output logic [7:0] reg_waddr_o,
  output logic [15:0] reg_wdata_o
);

  typedef struct packed {
    irs_pkg::irs_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rw;
    logic [1:0] bidx;
    logic lo_sel;
    logic mack;
    logic [7:0] ptr;
    logic full;
    logic [7:0] hi;
    logic oen;
    logic sda_out;
    logic wr;
    logic [7:0] waddr;
    logic [15:0] wdata;
  } irs_core_t;

  irs_core_t q;
  irs_core_t d;

  irs_line_if line ();
  irs_reg_if rif ();

  logic [6:0] own_addr;
  logic addr_hit;

  // ----------------------------------------------------------------
  // Pin synchroniser and register array
  // ----------------------------------------------------------------
  irs_line_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sel_i({addr_select_high_pin_i, addr_select_low_pin_i}),
    .lif(line)
  );

  irs_regfile u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rif(rif)
  );

  assign own_addr = {irs_pkg::DEV_ADDR_HI, line.sel};
  assign addr_hit = (q.sh[7:1] == own_addr);

  // Writes are issued one cycle after the byte closes
  assign rif.we = q.wr;
  assign rif.waddr = q.waddr;
  assign rif.wdata = q.wdata;
  assign rif.raddr = q.ptr;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.wr = 1'b0;
    // Open drain: data out stays low, only the enable moves
    d.sda_out = 1'b0;
    case (q.st)
      irs_pkg::IRS_IDLE: begin
        d.oen = 1'b1;
      end
      irs_pkg::IRS_ADDR, irs_pkg::IRS_RX: begin
        if (line.scl_rise) begin
          // Sample only on the rising clock, MSB arrives first
          d.sh = {q.sh[6:0], line.sda};
          d.cnt = q.cnt + 4'h1;
        end else if (line.scl_fall && q.cnt == irs_pkg::BYTE_BITS) begin
          d.cnt = 4'h0;
          if (q.st == irs_pkg::IRS_ADDR) begin
            if (addr_hit) begin
              d.st = irs_pkg::IRS_ACK;
              d.oen = 1'b0;
              d.rw = q.sh[0];
              d.bidx = irs_pkg::WB_ADDR;
            end else begin
              d.st = irs_pkg::IRS_IDLE;
            end
          end else begin
            d.st = irs_pkg::IRS_ACK;
            d.oen = 1'b0;
            case (q.bidx)
              irs_pkg::WB_ADDR: begin
                d.ptr = q.sh;
                d.full = 1'b0;
                d.bidx = irs_pkg::WB_HIGH;
              end
              irs_pkg::WB_HIGH: begin
                d.hi = q.sh;
                d.bidx = irs_pkg::WB_LOW;
              end
              default: begin
                // A lone high byte never reaches a register
                if (!q.full) begin
                  d.wr = 1'b1;
                  d.waddr = q.ptr;
                  d.wdata = {q.hi, q.sh};
                  if (q.ptr == irs_pkg::REG_LAST) begin
                    d.full = 1'b1;
                  end else begin
                    d.ptr = q.ptr + 8'h01;
                  end
                end
                d.bidx = irs_pkg::WB_HIGH;
              end
            endcase
          end
        end
      end
      irs_pkg::IRS_ACK: begin
        if (line.scl_fall) begin
          d.cnt = 4'h0;
          if (q.rw) begin
            d.st = irs_pkg::IRS_TX;
            d.tx = rif.rdata[15:8];
            d.oen = rif.rdata[15];
            d.lo_sel = 1'b0;
          end else begin
            d.st = irs_pkg::IRS_RX;
            d.oen = 1'b1;
          end
        end
      end
      irs_pkg::IRS_TX: begin
        if (line.scl_rise) begin
          d.cnt = q.cnt + 4'h1;
        end else if (line.scl_fall) begin
          if (q.cnt == irs_pkg::BYTE_BITS) begin
            d.cnt = 4'h0;
            d.oen = 1'b1;
            d.st = irs_pkg::IRS_MACK;
          end else begin
            // New bit goes out just after the falling clock
            d.tx = {q.tx[6:0], 1'b1};
            d.oen = q.tx[6];
          end
        end
      end
      irs_pkg::IRS_MACK: begin
        if (line.scl_rise) begin
          d.mack = ~line.sda;
          if (q.lo_sel && q.ptr != irs_pkg::REG_LAST) begin
            d.ptr = q.ptr + 8'h01;
          end
        end else if (line.scl_fall) begin
          if (q.mack) begin
            d.st = irs_pkg::IRS_TX;
            d.lo_sel = ~q.lo_sel;
            d.tx = q.lo_sel ? rif.rdata[15:8] : rif.rdata[7:0];
            d.oen = q.lo_sel ? rif.rdata[15] : rif.rdata[7];
          end else begin
            d.st = irs_pkg::IRS_IDLE;
            d.oen = 1'b1;
          end
        end
      end
      default: begin
        d.st = irs_pkg::IRS_IDLE;
        d.oen = 1'b1;
      end
    endcase
    // Frame boundaries override any byte in flight
    if (line.stop) begin
      d.st = irs_pkg::IRS_IDLE;
      d.oen = 1'b1;
    end else if (line.start) begin
      // Repeated start is taken in any state
      d.st = irs_pkg::IRS_ADDR;
      d.cnt = 4'h0;
      d.oen = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.st <= irs_pkg::IRS_IDLE;
      q.cnt <= 4'h0;
      q.sh <= 8'h00;
      q.tx <= 8'hff;
      q.rw <= 1'b0;
      q.bidx <= irs_pkg::WB_ADDR;
      q.lo_sel <= 1'b0;
      q.mack <= 1'b0;
      q.ptr <= irs_pkg::PTR_RESET;
      q.full <= 1'b0;
      q.hi <= 8'h00;
      q.oen <= 1'b1;
      q.sda_out <= 1'b0;
      q.wr <= 1'b0;
      q.waddr <= 8'h00;
      q.wdata <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  assign sda_o = q.sda_out;
  assign sda_oen_o = q.oen;
  assign reg_wr_o = q.wr;
  assign reg_waddr_o = q.waddr;
  assign reg_wdata_o = q.wdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_addr_done;
    q.st == irs_pkg::IRS_ADDR && line.scl_fall && q.cnt == irs_pkg::BYTE_BITS
      && !line.start && !line.stop;
  endsequence

  sequence s_low_done;
    q.st == irs_pkg::IRS_RX && q.bidx == irs_pkg::WB_LOW && line.scl_fall
      && q.cnt == irs_pkg::BYTE_BITS && !line.start && !line.stop;
  endsequence

  a_start_addr: assert property (line.start && !line.stop |=>
    q.st == irs_pkg::IRS_ADDR && q.cnt == 4'h0 && q.oen)
    else $error("start did not open address phase");

  a_stop_idle: assert property (line.stop |=> q.st == irs_pkg::IRS_IDLE && q.oen)
    else $error("stop did not return to idle");

  a_addr_miss: assert property (s_addr_done and !addr_hit |=>
    q.st == irs_pkg::IRS_IDLE && q.oen)
    else $error("foreign address was acknowledged");

  a_addr_hit: assert property (s_addr_done and addr_hit |=>
    !q.oen && q.rw == $past(q.sh[0]) && q.sh[7:3] == irs_pkg::DEV_ADDR_HI)
    else $error("own address not acknowledged");

  a_sda_scl_low: assert property ($changed(q.oen) && !$past(line.start)
    && !$past(line.stop) |-> !line.scl)
    else $error("data line moved while clock high");

  a_ptr_nowrap: assert property (q.ptr == irs_pkg::REG_LAST
    && !(q.st == irs_pkg::IRS_RX && q.bidx == irs_pkg::WB_ADDR) |=> q.ptr == irs_pkg::REG_LAST)
    else $error("pointer wrapped past last register");

  a_full_drop: assert property (s_low_done and q.full |=> !q.wr)
    else $error("write past last register not discarded");

  a_write_pair: assert property (s_low_done and !q.full |=>
    q.wr && q.wdata == {$past(q.hi), $past(q.sh)} && q.waddr == $past(q.ptr))
    else $error("register write mis-paired");

  a_read_high: assert property (q.st == irs_pkg::IRS_ACK && q.rw && line.scl_fall
    && !line.start && !line.stop |=> q.st == irs_pkg::IRS_TX && q.tx == rif.rdata[15:8])
    else $error("read did not start with high byte");

  a_read_nack: assert property (q.st == irs_pkg::IRS_MACK && !q.mack && line.scl_fall
    && !line.start && !line.stop |=> q.st == irs_pkg::IRS_IDLE ##1 q.oen)
    else $error("read continued after master nack");

  // ----------------------------------------------------------------
  // Line ownership and read path
  // ----------------------------------------------------------------
  // Ownership checks catch a slave not pulling in its ack slot, or still pulling when the master expects the line
  a_ack_drive: assert property (q.st == irs_pkg::IRS_ACK |-> !q.oen)
    else $error("acknowledge slot not driven low");

  a_idle_release: assert property (q.st == irs_pkg::IRS_IDLE |-> q.oen)
    else $error("idle slave holds the data line");

  a_mack_release: assert property (q.st == irs_pkg::IRS_MACK |-> q.oen)
    else $error("data line not released for master ack");

  a_tx_shift: assert property (q.st == irs_pkg::IRS_TX && line.scl_fall
    && q.cnt != irs_pkg::BYTE_BITS && !line.start && !line.stop |=> q.oen == $past(q.tx[6]))
    else $error("read bit out of order");

  sequence s_mack_go;
    q.st == irs_pkg::IRS_MACK && q.mack && line.scl_fall && !line.start && !line.stop;
  endsequence

  // Read data is picked at the fall, after the pointer step at the rise
  a_low_byte: assert property (s_mack_go and !q.lo_sel |=>
    q.st == irs_pkg::IRS_TX && q.lo_sel && q.tx == rif.rdata[7:0])
    else $error("low byte did not follow high byte");

  a_next_high: assert property (s_mack_go and q.lo_sel |=>
    q.st == irs_pkg::IRS_TX && !q.lo_sel && q.tx == rif.rdata[15:8])
    else $error("next register not read high byte first");

  a_ptr_step: assert property (q.st == irs_pkg::IRS_MACK && q.lo_sel
    && line.scl_rise && q.ptr != irs_pkg::REG_LAST && !line.start && !line.stop
    |=> q.ptr == $past(q.ptr) + 8'h01)
    else $error("read pointer did not advance");

  a_read_repeat: assert property (q.st == irs_pkg::IRS_MACK
    && q.ptr == irs_pkg::REG_LAST |=> q.ptr == irs_pkg::REG_LAST)
    else $error("read pointer left the last register");

  // The strobe must not stretch, or the array would take one pair twice
  a_wr_pulse: assert property (q.wr |=> !q.wr)
    else $error("register write strobe longer than one cycle");

endmodule

// *** verilog/irs_pkg.sv ***
// Package: constants, states and types of the two-wire register slave
package irs_pkg;

  // ----------------------------------------------------------------
  // Bus framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] DEV_ADDR_HI = 5'h0b;
  localparam logic [3:0] LINE_RESET = 4'h3;
  localparam logic [1:0] PREV_RESET = 2'h3;

  // ----------------------------------------------------------------
  // Register space
  // ----------------------------------------------------------------
  localparam int REG_COUNT = 64;
  localparam logic [7:0] REG_LAST = 8'h3f;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Byte position inside a write: address, high data, low data
  localparam logic [1:0] WB_ADDR = 2'h0;
  localparam logic [1:0] WB_HIGH = 2'h1;
  localparam logic [1:0] WB_LOW = 2'h2;

  // ----------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IRS_IDLE,
    IRS_ADDR,
    IRS_RX,
    IRS_ACK,
    IRS_TX,
    IRS_MACK
  } irs_state_t;

endpackage

// *** verilog/irs_if.sv ***
// Interfaces: synchronised line events and register file port
`timescale 1ns/1ps

interface irs_line_if;
  logic scl;
  logic sda;
  logic [1:0] sel;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, sda, sel, scl_rise, scl_fall, start, stop);
  modport dst (input scl, sda, sel, scl_rise, scl_fall, start, stop);
endinterface

interface irs_reg_if;
  logic we;
  logic [7:0] waddr;
  logic [15:0] wdata;
  logic [7:0] raddr;
  logic [15:0] rdata;
  modport port (input we, waddr, wdata, raddr, output rdata);
  modport user (output we, waddr, wdata, raddr, input rdata);
endinterface

// *** verilog/irs_line_sync.sv ***
// Synchroniser and start/stop/edge detector for the bus pins
`timescale 1ns/1ps

module irs_line_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [1:0] sel_i,
  irs_line_if.src lif
);

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic [1:0] prev;
  } irs_sync_t;

  irs_sync_t q;
  irs_sync_t d;

  // ----------------------------------------------------------------
  // Two flops per pin; only the second stage is looked at
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.meta = {sel_i, sda_i, scl_i};
    d.sync = q.meta;
    d.prev = q.sync[1:0];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.meta <= irs_pkg::LINE_RESET;
      q.sync <= irs_pkg::LINE_RESET;
      q.prev <= irs_pkg::PREV_RESET;
    end else begin
      q <= d;
    end
  end

  assign lif.scl = q.sync[0];
  assign lif.sda = q.sync[1];
  assign lif.sel = q.sync[3:2];
  assign lif.scl_rise = q.sync[0] & ~q.prev[0];
  assign lif.scl_fall = ~q.sync[0] & q.prev[0];
  // Data moving while the clock stays high marks a frame boundary
  assign lif.start = q.sync[0] & q.prev[0] & q.prev[1] & ~q.sync[1];
  assign lif.stop = q.sync[0] & q.prev[0] & ~q.prev[1] & q.sync[1];

  a_sync_depth: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i, 2) |-> lif.scl == $past(scl_i, 2))
    else $error("clock line not seen two cycles after the pin");

endmodule

// *** verilog/irs_regfile.sv ***
// Array of 16-bit registers behind the slave's address pointer
`timescale 1ns/1ps

module irs_regfile (
  input wire logic clk_i,
  input wire logic rst_i,
  irs_reg_if.port rif
);

  typedef struct packed {
    logic [irs_pkg::REG_COUNT-1:0][15:0] mem;
  } irs_regs_t;

  irs_regs_t q;
  irs_regs_t d;

  always_comb begin
    d = q;
    if (rif.we && rif.waddr <= irs_pkg::REG_LAST) begin
      d.mem[rif.waddr[5:0]] = rif.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.mem <= {irs_pkg::REG_COUNT{irs_pkg::REG_RESET}};
    end else begin
      q <= d;
    end
  end

  // Out-of-range reads return zero rather than aliasing
  assign rif.rdata = (rif.raddr <= irs_pkg::REG_LAST) ? q.mem[rif.raddr[5:0]] : 16'h0000;

  a_reg_store: assert property (@(posedge clk_i) disable iff (rst_i)
    rif.we && rif.waddr <= irs_pkg::REG_LAST |=> q.mem[$past(rif.waddr[5:0])] == $past(rif.wdata))
    else $error("register write not stored");

endmodule

// *** verif/irs_master_model.sv ***
// Bus master model: drives the clock pin and pulls the data line low
`timescale 1ns/1ps

// Ten system clocks per bit: the nearest whole count to a 48 ns bus clock
module irs_master_model #(
  parameter int T_SHORT = 2,
  parameter int T_LONG = 3
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Also serves as repeated start
  task automatic start_cond();
    sda_low_o <= 1'b0;
    wait_n(T_LONG);
    scl_o <= 1'b1;
    wait_n(T_LONG);
    sda_low_o <= 1'b1;
    wait_n(T_LONG);
    scl_o <= 1'b0;
    wait_n(T_LONG);
  endtask

  task automatic stop_cond();
    sda_low_o <= 1'b1;
    wait_n(T_LONG);
    scl_o <= 1'b1;
    wait_n(T_LONG);
    sda_low_o <= 1'b0;
    wait_n(T_LONG);
  endtask

  // Data moves three clocks after the fall, so the slave's hold is met
  task automatic bit_xfer(input logic tx, output logic rx);
    sda_low_o <= ~tx;
    wait_n(T_SHORT);
    scl_o <= 1'b1;
    wait_n(T_SHORT);
    rx = sda_i;
    wait_n(T_LONG);
    scl_o <= 1'b0;
    wait_n(T_LONG);
  endtask

  task automatic byte_xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                           output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(tx[i], rx[i]);
    end
    bit_xfer(ack_tx, ack_rx);
  endtask
endmodule

// *** verif/i2c_register_access_slave_bench.sv ***
// Self-checking bench of the two-wire register slave
`timescale 1ns/1ps

module i2c_register_access_slave_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_low;
  logic sda_w;
  logic sda_out;
  logic sda_oen;
  logic [1:0] sel = 2'h0;
  logic reg_wr;
  logic [7:0] reg_waddr;
  logic [15:0] reg_wdata;
  logic [15:0] shadow [64];
  logic [23:0] exp_wr [$];
  logic [7:0] rx;
  logic ak;
  int mismatches = 0;
  int n_checks = 0;

  always #2.5 clk = ~clk;

  // Open drain with pull-up: low if either party pulls
  assign sda_w = ~(sda_low | ~sda_oen);

  irs_slave u_irs_slave (
    .clk_i(clk),
    .rst_i(rst),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_out),
    .sda_oen_o(sda_oen),
    .addr_select_low_pin_i(sel[0]),
    .addr_select_high_pin_i(sel[1]),
    .reg_wr_o(reg_wr),
    .reg_waddr_o(reg_waddr),
    .reg_wdata_o(reg_wdata)
  );

  irs_master_model u_irs_master_model (
    .clk_i(clk),
    .sda_i(sda_w),
    .scl_o(scl),
    .sda_low_o(sda_low)
  );

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A strobe with no note queued is a write that should have been dropped
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      if (exp_wr.size() == 0) begin
        check("unexpected write", 24'hffffff, {reg_waddr, reg_wdata});
      end else begin
        check("register write", exp_wr.pop_front(), {reg_waddr, reg_wdata});
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] dev_addr(input logic rw);
    return {5'h0b, sel, rw};
  endfunction

  task automatic xb(input logic [7:0] tx, input logic am);
    u_irs_master_model.byte_xfer(tx, am, rx, ak);
  endtask

  // Note goes in before the low byte: the strobe lands inside its ack slot
  task automatic wr_regs(input logic [7:0] ptr, input int nb);
    logic [15:0] d;
    logic full;
    full = 1'b0;
    d = 16'h0000;
    u_irs_master_model.start_cond();
    xb(dev_addr(1'b0), 1'b1);
    check("address ack", 24'h0, 24'(ak));
    check("data out level", 24'h0, 24'(sda_out));
    xb(ptr, 1'b1);
    for (int b = 0; b < nb; b++) begin
      if (b % 2 == 0) begin
        d = 16'($urandom);
        xb(d[15:8], 1'b1);
      end else begin
        if (!full) begin
          exp_wr.push_back({ptr, d});
          shadow[ptr[5:0]] = d;
          full = (ptr == 8'h3f);
          ptr = full ? ptr : ptr + 8'h01;
        end
        xb(d[7:0], 1'b1);
      end
      check("data ack", 24'h0, 24'(ak));
    end
  endtask

  task automatic rd_regs(input logic [7:0] ptr, input int n);
    u_irs_master_model.start_cond();
    xb(dev_addr(1'b0), 1'b1);
    xb(ptr, 1'b1);
    u_irs_master_model.start_cond();
    xb(dev_addr(1'b1), 1'b1);
    check("read address ack", 24'h0, 24'(ak));
    for (int i = 0; i < n; i++) begin
      xb(8'hff, 1'b0);
      check("read high byte", 24'(shadow[ptr[5:0]][15:8]), 24'(rx));
      xb(8'hff, (i == n - 1));
      check("read low byte", 24'(shadow[ptr[5:0]][7:0]), 24'(rx));
      ptr = (ptr == 8'h3f) ? ptr : ptr + 8'h01;
    end
    u_irs_master_model.stop_cond();
  endtask

  task automatic test_end(input string name);
    $display("Test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] p;
    logic b;
    void'($urandom(32'haec7cce0));
    for (int i = 0; i < 64; i++) begin
      shadow[i] = 16'h0000;
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // Each pin setting; a stray high byte before stop must be dropped
    for (int s = 0; s < 4; s++) begin
      sel <= 2'(s);
      p = 8'($urandom_range(0, 59));
      @(posedge clk);
      wr_regs(p, 5);
      u_irs_master_model.stop_cond();
      rd_regs(p, 2);
      test_end("select pins");
    end
    wr_regs(8'h3e, 6);
    u_irs_master_model.stop_cond();
    rd_regs(8'h3e, 3);
    test_end("last register");
    sel <= 2'h1;
    @(posedge clk);
    u_irs_master_model.start_cond();
    xb({5'h0b, 2'h2, 1'b0}, 1'b1);
    check("foreign address ack", 24'h1, 24'(ak));
    xb(8'h05, 1'b1);
    check("idle slave ack", 24'h1, 24'(ak));
    xb(8'h12, 1'b1);
    xb(8'h34, 1'b1);
    u_irs_master_model.stop_cond();
    test_end("foreign address");
    // Stop inside the low byte abandons the pair
    u_irs_master_model.start_cond();
    xb(dev_addr(1'b0), 1'b1);
    xb(8'h07, 1'b1);
    xb(8'ha5, 1'b1);
    for (int i = 0; i < 3; i++) begin
      u_irs_master_model.bit_xfer(1'b0, b);
    end
    u_irs_master_model.stop_cond();
    rd_regs(8'h07, 1);
    test_end("stop abort");
    repeat (20) @(posedge clk);
    check("writes left", 24'h0, 24'(exp_wr.size()));
    finish_test();
  end

  // Whole run is about 40 us of bus traffic
  initial begin
    #200000;
    mismatches++;
    $display("Watchdog expired");
    finish_test();
  end
endmodule
